/* File: logic/dtoc_consts.vh */
`ifndef DTOC_CONSTS_VH
`define DTOC_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DTOC_OFS_LOCK 16'h8300
`define DTOC_OFS_TIMING_CFG 16'h8304
`define DTOC_OFS_OUTPUT_CFG 16'h830c
`define DTOC_OFS_IRQ_STATUS 16'h8340
`define DTOC_OFS_IRQ_MASK 16'h8344
`define DTOC_OFS_H_TOTAL 16'h8350
`define DTOC_OFS_H_SYNC 16'h8354
`define DTOC_OFS_V_TOTAL 16'h8358
`define DTOC_OFS_V_SYNC 16'h835c

// ----------------------------------------
// timing configuration fields
// ----------------------------------------
`define DTOC_TC_PIXEL_PORT_EN 0
`define DTOC_TC_VSYNC_EN 1
`define DTOC_TC_HSYNC_EN 2
`define DTOC_TC_BLANK_EN 3
`define DTOC_TC_DDC_CLK 4
`define DTOC_TC_TIMING_GEN_ENABLE_EN 5
`define DTOC_TC_VIRQ_EN 6
`define DTOC_TC_BLINK_EN 7
`define DTOC_TC_HSYNC_POL 8
`define DTOC_TC_VSYNC_POL 9
`define DTOC_TC_BLINK_RATE 16
`define DTOC_TC_RST 32'h00000000
`define DTOC_TC_WMASK 32'h000103ff

// ----------------------------------------
// output configuration fields
// ----------------------------------------
`define DTOC_OC_LB_MODE 15
`define DTOC_OC_LB_RW_SEL 14
`define DTOC_OC_RST 32'h00000000
`define DTOC_OC_WMASK 32'h0000ffff

// ----------------------------------------
// lock, interrupts, timing defaults
// ----------------------------------------
// unlock key value is arbitrary
`define DTOC_UNLOCK_KEY 32'h0000a5c3
`define DTOC_IRQ_VSYNC 0
`define DTOC_IRQ_REJECT 1
`define DTOC_IRQ_RST 2'h0
`define DTOC_H_TOTAL_RST 32'h03200280
`define DTOC_H_SYNC_RST 32'h02f00290
`define DTOC_V_TOTAL_RST 32'h020d01e0
`define DTOC_V_SYNC_RST 32'h01ec01ea
`define DTOC_CNT_MASK 32'h0fff0fff

`endif

/* File: logic/dtoc_blink.v */
`timescale 1ns/10ps
`include "dtoc_consts.vh"

// ----------------------------------------
// frame based blink phase for cursor and text
// ----------------------------------------
module dtoc_blink (
	// clock and reset
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire clear_i,
	// controls
	input wire frame_tick_i,
	input wire blink_enable_i,
	input wire blink_rate_select_i,
	// visibility
	output reg cursor_visible_o,
	output reg text_visible_o
);

	reg [5:0] frame_cnt;
	reg [5:0] next_frame_cnt;

	// frame counter advances once per vertical sync
	always @* begin
		next_frame_cnt = frame_cnt;
		if (frame_tick_i) begin
			next_frame_cnt = frame_cnt + 6'h01;
		end
	end

	// rate 0: cursor 8 of 16, text 16 of 32; rate 1 doubles both
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_cnt <= 6'h00;
			cursor_visible_o <= 1'b1;
			text_visible_o <= 1'b1;
		end else if (clear_i) begin
			frame_cnt <= 6'h00;
			cursor_visible_o <= 1'b1;
			text_visible_o <= 1'b1;
		end else begin
			frame_cnt <= next_frame_cnt;
			cursor_visible_o <= ~blink_enable_i |
				~(blink_rate_select_i ? frame_cnt[4] : frame_cnt[3]);
			text_visible_o <= ~blink_enable_i |
				~(blink_rate_select_i ? frame_cnt[5] : frame_cnt[4]);
		end
	end

endmodule // dtoc_blink

/* File: logic/dtoc_top.v */
`timescale 1ns/10ps
`include "dtoc_consts.vh"

module dtoc_top (
	// clock and reset
	input wire core_clk_i,
	input wire sys_rst_i,
	// register port
	input wire [15:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_write_i,
	input wire reg_read_i,
	output reg [31:0] reg_rdata_o,
	// power sequencing
	input wire panel_power_on_i,
	// display pins
	output reg crt_horizontal_sync_out_o,
	output reg crt_vertical_sync_out_o,
	output reg display_enable_out_o,
	output reg fp_hsync_o,
	output reg fp_vsync_o,
	output reg pixel_port_enable_o,
	// blink phase
	output wire cursor_visible_o,
	output wire text_blink_visible_o,
	// line buffer diagnostics
	output reg line_buffer_line_buffer_mode_a_o,
	output reg lb_wr_ptr_reset_o,
	output reg lb_write_addr_en_o,
	output reg lb_read_addr_en_o,
	// interrupts
	output reg vsync_irq_o,
	output wire irq_o
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	reg [31:0] display_timing_config;
	reg [31:0] display_output_config;
	reg [31:0] h_total_cfg;
	reg [31:0] h_sync_cfg;
	reg [31:0] v_total_cfg;
	reg [31:0] v_sync_cfg;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg unlocked;
	reg [1:0] next_irq_status;

	// decoded controls
	wire timing_gen_enable;
	wire vsync_irq_enable;
	wire blink_enable;
	wire blink_rate_select;
	wire ddc_serial_clock_bit;
	wire blank_enable;
	wire crt_horizontal_sync_out_enable;
	wire crt_vertical_sync_out_enable;
	wire pixel_port_enable;
	wire crt_horizontal_sync_out_polarity;
	wire crt_vertical_sync_out_polarity;
	wire line_buffer_mode_a;
	wire line_buffer_rw_select;

	// write decode
	wire wr_lock, wr_tc, wr_oc, wr_stat, wr_mask, wr_timing, timing_reject;

	// display domain
	wire disp_clear;
	reg [11:0] h_cnt, v_cnt, next_h_cnt, next_v_cnt;
	reg h_sync_raw, v_sync_raw, active_raw, v_sync_prev;
	wire frame_tick;
	reg ppe_prev;
	reg line_buffer_mode_a_prev;

	assign timing_gen_enable = display_timing_config[`DTOC_TC_TIMING_GEN_ENABLE_EN];
	assign vsync_irq_enable = display_timing_config[`DTOC_TC_VIRQ_EN];
	assign blink_enable = display_timing_config[`DTOC_TC_BLINK_EN];
	assign blink_rate_select = display_timing_config[`DTOC_TC_BLINK_RATE];
	assign ddc_serial_clock_bit = display_timing_config[`DTOC_TC_DDC_CLK];
	assign blank_enable = display_timing_config[`DTOC_TC_BLANK_EN];
	assign crt_horizontal_sync_out_enable = display_timing_config[`DTOC_TC_HSYNC_EN];
	assign crt_vertical_sync_out_enable = display_timing_config[`DTOC_TC_VSYNC_EN];
	assign pixel_port_enable = display_timing_config[`DTOC_TC_PIXEL_PORT_EN];
	assign crt_horizontal_sync_out_polarity = display_timing_config[`DTOC_TC_HSYNC_POL];
	assign crt_vertical_sync_out_polarity = display_timing_config[`DTOC_TC_VSYNC_POL];
	assign line_buffer_mode_a = display_output_config[`DTOC_OC_LB_MODE];
	assign line_buffer_rw_select = display_output_config[`DTOC_OC_LB_RW_SEL];

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// config registers only take writes while unlocked
	assign wr_lock = reg_write_i & (reg_addr_i == `DTOC_OFS_LOCK);
	assign wr_tc = reg_write_i & unlocked &
		(reg_addr_i == `DTOC_OFS_TIMING_CFG);
	assign wr_oc = reg_write_i & unlocked &
		(reg_addr_i == `DTOC_OFS_OUTPUT_CFG);
	assign wr_stat = reg_write_i & (reg_addr_i == `DTOC_OFS_IRQ_STATUS);
	assign wr_mask = reg_write_i & (reg_addr_i == `DTOC_OFS_IRQ_MASK);
	assign wr_timing = reg_write_i & unlocked &
		((reg_addr_i == `DTOC_OFS_H_TOTAL) |
		(reg_addr_i == `DTOC_OFS_H_SYNC) |
		(reg_addr_i == `DTOC_OFS_V_TOTAL) |
		(reg_addr_i == `DTOC_OFS_V_SYNC));
	assign timing_reject = wr_timing & timing_gen_enable;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// lock register: writing the key unlocks, anything else locks
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			unlocked <= 1'b1;
			display_timing_config <= `DTOC_TC_RST;
			display_output_config <= `DTOC_OC_RST;
			irq_mask <= `DTOC_IRQ_RST;
		end else begin
			if (wr_lock) begin
				unlocked <= (reg_wdata_i == `DTOC_UNLOCK_KEY);
			end
			if (wr_tc) begin
				display_timing_config <= reg_wdata_i & `DTOC_TC_WMASK;
			end
			if (wr_oc) begin
				display_output_config <= reg_wdata_i & `DTOC_OC_WMASK;
			end
			if (wr_mask) begin
				irq_mask <= reg_wdata_i[1:0];
			end
		end
	end

	// timing registers only change while the generator is stopped
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			h_total_cfg <= `DTOC_H_TOTAL_RST;
			h_sync_cfg <= `DTOC_H_SYNC_RST;
			v_total_cfg <= `DTOC_V_TOTAL_RST;
			v_sync_cfg <= `DTOC_V_SYNC_RST;
		end else if (wr_timing & ~timing_gen_enable) begin
			case (reg_addr_i)
			`DTOC_OFS_H_TOTAL: h_total_cfg <= reg_wdata_i & `DTOC_CNT_MASK;
			`DTOC_OFS_H_SYNC: h_sync_cfg <= reg_wdata_i & `DTOC_CNT_MASK;
			`DTOC_OFS_V_TOTAL: v_total_cfg <= reg_wdata_i & `DTOC_CNT_MASK;
			`DTOC_OFS_V_SYNC: v_sync_cfg <= reg_wdata_i & `DTOC_CNT_MASK;
			default: h_total_cfg <= h_total_cfg;
			endcase
		end
	end

	// ----------------------------------------
	// timing generator
	// ----------------------------------------
	// synchronous clear rather than a derived async reset, so a
	// register write cannot glitch the display logic
	assign disp_clear = ~timing_gen_enable;

	// raster counters wrap at the programmed totals
	always @* begin
		next_h_cnt = h_cnt + 12'h001;
		next_v_cnt = v_cnt;
		if (h_cnt >= h_total_cfg[27:16] - 12'h001) begin
			next_h_cnt = 12'h000;
			next_v_cnt = v_cnt + 12'h001;
			if (v_cnt >= v_total_cfg[27:16] - 12'h001) begin
				next_v_cnt = 12'h000;
			end
		end
	end

	// counters and raw sync, active flags
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			h_cnt <= 12'h000;
			v_cnt <= 12'h000;
			h_sync_raw <= 1'b0;
			v_sync_raw <= 1'b0;
			active_raw <= 1'b0;
			v_sync_prev <= 1'b0;
		end else if (disp_clear) begin
			h_cnt <= 12'h000;
			v_cnt <= 12'h000;
			h_sync_raw <= 1'b0;
			v_sync_raw <= 1'b0;
			active_raw <= 1'b0;
			v_sync_prev <= 1'b0;
		end else begin
			h_cnt <= next_h_cnt;
			v_cnt <= next_v_cnt;
			h_sync_raw <= (h_cnt >= h_sync_cfg[11:0]) &
				(h_cnt < h_sync_cfg[27:16]);
			v_sync_raw <= (v_cnt >= v_sync_cfg[11:0]) &
				(v_cnt < v_sync_cfg[27:16]);
			active_raw <= (h_cnt < h_total_cfg[11:0]) &
				(v_cnt < v_total_cfg[11:0]);
			v_sync_prev <= v_sync_raw;
		end
	end

	// one pulse at the leading edge of each vertical sync
	assign frame_tick = v_sync_raw & ~v_sync_prev;

	// ----------------------------------------
	// display outputs
	// ----------------------------------------
	// crt pins honour the power-saving enables; panel pins do not
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			crt_horizontal_sync_out_o <= 1'b0;
			crt_vertical_sync_out_o <= 1'b0;
			display_enable_out_o <= 1'b0;
			fp_hsync_o <= 1'b0;
			fp_vsync_o <= 1'b0;
		end else begin
			crt_horizontal_sync_out_o <= crt_horizontal_sync_out_enable &
				(h_sync_raw ^ crt_horizontal_sync_out_polarity);
			// the serial clock takes over the pin while sync is off
			crt_vertical_sync_out_o <= crt_vertical_sync_out_enable ?
				(v_sync_raw ^ crt_vertical_sync_out_polarity) :
				ddc_serial_clock_bit;
			display_enable_out_o <= blank_enable & active_raw;
			fp_hsync_o <= panel_power_on_i & h_sync_raw;
			fp_vsync_o <= panel_power_on_i & v_sync_raw;
		end
	end

	// pixel port switches only on edges of its enable bit
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ppe_prev <= 1'b0;
			pixel_port_enable_o <= 1'b0;
		end else begin
			ppe_prev <= pixel_port_enable;
			if (pixel_port_enable & ~ppe_prev) begin
				pixel_port_enable_o <= 1'b1;
			end else if (~pixel_port_enable & ppe_prev) begin
				pixel_port_enable_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// blink phase
	// ----------------------------------------
	// blinking is frame based, so it clears to visible while the generator is stopped
	dtoc_blink u_blink (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(disp_clear),
		.frame_tick_i(frame_tick),
		.blink_enable_i(blink_enable),
		.blink_rate_select_i(blink_rate_select),
		.cursor_visible_o(cursor_visible_o),
		.text_visible_o(text_blink_visible_o)
	);

	// ----------------------------------------
	// line buffer diagnostics
	// ----------------------------------------
	// pointer reset is a one-cycle pulse on entering diagnostic mode
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line_buffer_mode_a_prev <= 1'b0;
			line_buffer_line_buffer_mode_a_o <= 1'b0;
			lb_wr_ptr_reset_o <= 1'b0;
			lb_write_addr_en_o <= 1'b0;
			lb_read_addr_en_o <= 1'b0;
		end else begin
			line_buffer_mode_a_prev <= line_buffer_mode_a;
			line_buffer_line_buffer_mode_a_o <= line_buffer_mode_a;
			lb_wr_ptr_reset_o <= line_buffer_mode_a & ~line_buffer_mode_a_prev;
			lb_write_addr_en_o <= line_buffer_mode_a &
				~line_buffer_rw_select;
			lb_read_addr_en_o <= line_buffer_mode_a &
				line_buffer_rw_select;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// vertical irq: armed by its enable, held until the enable drops
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			vsync_irq_o <= 1'b0;
		end else if (~vsync_irq_enable) begin
			vsync_irq_o <= 1'b0;
		end else if (frame_tick) begin
			vsync_irq_o <= 1'b1;
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always @* begin
		next_irq_status = irq_status;
		if (wr_stat) begin
			next_irq_status = irq_status & ~reg_wdata_i[1:0];
		end
		if (frame_tick) begin
			next_irq_status[`DTOC_IRQ_VSYNC] = 1'b1;
		end
		if (timing_reject) begin
			next_irq_status[`DTOC_IRQ_REJECT] = 1'b1;
		end
	end

	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_status <= `DTOC_IRQ_RST;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// ----------------------------------------
	// read back
	// ----------------------------------------
	// unmapped offsets read zero; reads have no side effects
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_read_i) begin
			case (reg_addr_i)
			`DTOC_OFS_LOCK: reg_rdata_o <= {31'h00000000, unlocked};
			`DTOC_OFS_TIMING_CFG: reg_rdata_o <= display_timing_config;
			`DTOC_OFS_OUTPUT_CFG:
				reg_rdata_o <= display_output_config;
			`DTOC_OFS_IRQ_STATUS: reg_rdata_o <= {30'h00000000, irq_status};
			`DTOC_OFS_IRQ_MASK: reg_rdata_o <= {30'h00000000, irq_mask};
			`DTOC_OFS_H_TOTAL: reg_rdata_o <= h_total_cfg;
			`DTOC_OFS_H_SYNC: reg_rdata_o <= h_sync_cfg;
			`DTOC_OFS_V_TOTAL: reg_rdata_o <= v_total_cfg;
			`DTOC_OFS_V_SYNC: reg_rdata_o <= v_sync_cfg;
			default: reg_rdata_o <= 32'h00000000;
			endcase
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

endmodule // dtoc_top

/* File: verification/dtoc_top_assertions.sv */
`timescale 1ns/10ps
`include "dtoc_consts.vh"

// ----------------------------------------
// port level checker for dtoc_top
// ----------------------------------------
module dtoc_assert_chk (
	// clock and reset
	input wire core_clk_i,
	input wire sys_rst_i,
	// register port
	input wire [15:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_write_i,
	// display pins
	input wire crt_horizontal_sync_out_o,
	input wire crt_vertical_sync_out_o,
	input wire display_enable_out_o,
	input wire pixel_port_enable_o,
	input wire cursor_visible_o,
	input wire text_blink_visible_o,
	// diagnostics and interrupt
	input wire line_buffer_line_buffer_mode_a_o,
	input wire lb_wr_ptr_reset_o,
	input wire lb_write_addr_en_o,
	input wire lb_read_addr_en_o,
	input wire vsync_irq_o
);
reg unlocked;
reg [31:0] tc;
reg [31:0] oc;
// shadow config words, so every pin check can name its cause
always @(posedge core_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		unlocked <= 1'b1;
		tc <= 32'h0;
		oc <= 32'h0;
	end else if (reg_write_i) begin
		if (reg_addr_i == `DTOC_OFS_LOCK)
			unlocked <= reg_wdata_i == `DTOC_UNLOCK_KEY;
		if (unlocked && reg_addr_i == `DTOC_OFS_TIMING_CFG)
			tc <= reg_wdata_i;
		if (unlocked && reg_addr_i == `DTOC_OFS_OUTPUT_CFG)
			oc <= reg_wdata_i;
	end
end
default clocking cb @(posedge core_clk_i); endclocking
default disable iff (sys_rst_i);
a_hsync_off: assert property (!tc[2] && !$past(tc[2])
	|-> !crt_horizontal_sync_out_o) else $error("hsync not low");
a_vsync_ddc: assert property (!tc[1] && !$past(tc[1])
	|-> crt_vertical_sync_out_o == $past(tc[4])) else $error("vsync pin");
a_blank_off: assert property (!$past(tc[3])
	|-> !display_enable_out_o) else $error("display enable not low");
a_port_follow: assert property (pixel_port_enable_o == $past(tc[0]))
	else $error("pixel port enable wrong");
a_virq_clear: assert property (!$past(tc[6]) |-> !vsync_irq_o)
	else $error("vsync irq not cleared");
a_virq_hold: assert property (vsync_irq_o && tc[6]
	|=> vsync_irq_o) else $error("vsync irq dropped");
a_line_buffer_mode_a_follow: assert property (line_buffer_line_buffer_mode_a_o == $past(oc[15]))
	else $error("line_buffer_mode_a mode wrong");
a_ptr_pulse: assert property (lb_wr_ptr_reset_o ==
	(line_buffer_line_buffer_mode_a_o && !$past(line_buffer_line_buffer_mode_a_o)))
	else $error("pointer reset pulse wrong");
a_addr_select: assert property (
	lb_write_addr_en_o == ($past(oc[15]) && !$past(oc[14])) &&
	lb_read_addr_en_o == ($past(oc[15]) && $past(oc[14])))
	else $error("buffer address select wrong");
a_cursor_off: assert property ((!tc[7]) [*3] |-> cursor_visible_o)
	else $error("cursor blinks while disabled");
a_text_off: assert property ((!tc[7]) [*3] |-> text_blink_visible_o)
	else $error("text blinks while disabled");
c_virq: cover property ($rose(vsync_irq_o));
c_ptr: cover property (lb_wr_ptr_reset_o);
c_blink: cover property ($fell(cursor_visible_o));
endmodule // dtoc_assert_chk

bind dtoc_top dtoc_assert_chk dtoc_assert_chk_i (.*);

/* File: verification/dtoc_monitor.sv */
`timescale 1ns/10ps

// ----------------------------------------
// crt monitor: measures sync pulses and frames
// ----------------------------------------
module dtoc_monitor (
	// display clock
	input wire core_clk_i,
	// crt pins
	input wire hsync_i,
	input wire vsync_i,
	input wire disp_en_i,
	// measurements
	output integer hs_low_o,
	output integer frames_o,
	output integer de_seen_o
);
integer run;
initial begin
	run = 0;
	hs_low_o = 0;
	frames_o = 0;
	de_seen_o = 0;
end
// width of the last low hsync pulse, and active cycles seen
always @(posedge core_clk_i) begin
	if (!hsync_i)
		run <= run + 1;
	else if (run > 0) begin
		hs_low_o <= run;
		run <= 0;
	end
	if (disp_en_i)
		de_seen_o <= de_seen_o + 1;
end
// a frame starts on each leading vsync edge
always @(posedge vsync_i)
	frames_o <= frames_o + 1;
endmodule // dtoc_monitor

/* File: verification/display_timing_output_control_bench.sv */
`timescale 1ns/10ps
`include "dtoc_consts.vh"

module display_timing_output_control_bench;
localparam [15:0] LKR = `DTOC_OFS_LOCK;
localparam [15:0] TCR = `DTOC_OFS_TIMING_CFG;
localparam [15:0] OCR = `DTOC_OFS_OUTPUT_CFG;
localparam [15:0] STR = `DTOC_OFS_IRQ_STATUS;
localparam [15:0] MKR = `DTOC_OFS_IRQ_MASK;
reg core_clk_i = 1'b0;
reg sys_rst_i = 1'b1;
reg [15:0] reg_addr_i = 16'h0;
reg [31:0] reg_wdata_i = 32'h0;
reg reg_write_i = 1'b0;
reg reg_read_i = 1'b0;
reg panel_power_on_i = 1'b0;
wire [31:0] reg_rdata_o;
wire crt_horizontal_sync_out_o, crt_vertical_sync_out_o;
wire display_enable_out_o, fp_hsync_o, fp_vsync_o, pixel_port_enable_o;
wire cursor_visible_o, text_blink_visible_o, line_buffer_line_buffer_mode_a_o;
wire lb_wr_ptr_reset_o, lb_write_addr_en_o, lb_read_addr_en_o;
wire vsync_irq_o, irq_o;
wire [31:0] hs_low, frames, de_seen;
integer err_total = 0;
integer checked = 0;
integer i, f0, f1, f2;
reg [31:0] seed = 32'h0000a8af;
bit [31:0] mdl [int];

// 25 MHz clock
always #20 core_clk_i = ~core_clk_i;

dtoc_top dtoc_top_i (.*);
dtoc_monitor dtoc_monitor_i (.core_clk_i(core_clk_i),
	.hsync_i(crt_horizontal_sync_out_o), .vsync_i(crt_vertical_sync_out_o),
	.disp_en_i(display_enable_out_o), .hs_low_o(hs_low),
	.frames_o(frames), .de_seen_o(de_seen));

function [31:0] xs(input [31:0] s);
	xs = s ^ (s << 13);
	xs = xs ^ (xs >> 17);
	xs = xs ^ (xs << 5);
endfunction

task chk(input [31:0] s, input [31:0] e);
	begin
		checked = checked + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	end
endtask

// one write cycle, then the model takes the same write
task wr(input [15:0] ad, input [31:0] d);
	begin
		reg_addr_i <= ad;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge core_clk_i);
		reg_write_i <= 1'b0;
		if (ad == LKR)
			mdl[LKR] = (d == `DTOC_UNLOCK_KEY);
		else if (ad == STR)
			mdl[STR] = mdl[STR] & ~d;
		else if (ad == MKR)
			mdl[MKR] = d & 32'h3;
		else if (mdl[LKR][0] && ad == TCR)
			mdl[TCR] = d & `DTOC_TC_WMASK;
		else if (mdl[LKR][0] && ad == OCR)
			mdl[OCR] = d & `DTOC_OC_WMASK;
		else if (mdl[LKR][0] && ad >= 16'h8350 && ad <= 16'h835c) begin
			if (mdl[TCR][5])
				mdl[STR][1] = 1'b1;
			else
				mdl[ad] = d & `DTOC_CNT_MASK;
		end
		@(posedge core_clk_i);
		#1;
	end
endtask

// read data stand only in the cycle after the strobe
task rd(input [15:0] ad, input [31:0] m);
	begin
		reg_addr_i <= ad;
		reg_read_i <= 1'b1;
		@(posedge core_clk_i);
		reg_read_i <= 1'b0;
		@(negedge core_clk_i);
		chk(reg_rdata_o & m, (mdl.exists(ad) ? mdl[ad] : 32'h0) & m);
		@(posedge core_clk_i);
		#1;
	end
endtask

// frame count at the next change of cursor (sel 0) or text visibility
task tog(input sel, output integer f);
	reg v;
	integer k;
	begin
		v = sel ? text_blink_visible_o : cursor_visible_o;
		for (k = 0; k < 20000 &&
			(sel ? text_blink_visible_o : cursor_visible_o) === v; k = k + 1)
			@(posedge core_clk_i);
		f = frames;
	end
endtask

// high cycles of panel syncs and crt syncs over one whole 40x10 frame
task frame_hist(output integer fh, output integer fv, output integer ch);
	integer k;
	begin
		fh = 0;
		fv = 0;
		ch = 0;
		for (k = 0; k < 400; k = k + 1) begin
			@(posedge core_clk_i);
			fh = fh + fp_hsync_o;
			fv = fv + fp_vsync_o;
			ch = ch + crt_horizontal_sync_out_o + crt_vertical_sync_out_o;
		end
	end
endtask

task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
endtask

// a hang counts as a mismatch
initial begin
	#3600000;
	err_total = err_total + 1;
	tally_and_finish;
end

initial begin
	mdl[LKR] = 32'h1;
	mdl[TCR] = 32'h0;
	mdl[OCR] = 32'h0;
	mdl[STR] = 32'h0;
	mdl[MKR] = 32'h0;
	mdl[16'h8350] = `DTOC_H_TOTAL_RST;
	mdl[16'h8354] = `DTOC_H_SYNC_RST;
	mdl[16'h8358] = `DTOC_V_TOTAL_RST;
	mdl[16'h835c] = `DTOC_V_SYNC_RST;
	repeat (3) @(posedge core_clk_i);
	sys_rst_i <= 1'b0;
	panel_power_on_i <= 1'b1;
	@(posedge core_clk_i);
	#1;
	// reset values, unmapped words 0x8308 and 0x8310 among them
	for (i = 0; i < 96; i = i + 4)
		rd(16'h8300 + i[15:0], 32'hffffffff);
	// random output config words, line_buffer_mode_a bit alternating
	for (i = 0; i < 6; i = i + 1) begin
		seed = xs(seed);
		wr(OCR, {seed[31:16], i[0], seed[14:0]});
		rd(OCR, 32'hffffffff);
		chk(line_buffer_line_buffer_mode_a_o, i[0]);
		chk(lb_write_addr_en_o, i[0] & ~seed[14]);
		chk(lb_read_addr_en_o, i[0] & seed[14]);
	end
	// locked writes are dropped
	wr(LKR, 32'h0);
	wr(OCR, 32'h00001234);
	rd(OCR, 32'hffffffff);
	rd(LKR, 32'hffffffff);
	wr(LKR, `DTOC_UNLOCK_KEY);
	// small raster while the generator is off: 40x10 lines
	wr(16'h8350, 32'h00280020);
	wr(16'h8354, 32'h0024001e);
	wr(16'h8358, 32'h000a0008);
	wr(16'h835c, 32'h00090007);
	for (i = 0; i < 16; i = i + 4)
		rd(16'h8350 + i[15:0], 32'hffffffff);
	// generator on, hsync low pulses, blank off, pixel port on
	wr(TCR, 32'h00000127);
	repeat (1000) @(posedge core_clk_i);
	chk(hs_low, 32'h6);
	chk(de_seen, 32'h0);
	chk(pixel_port_enable_o, 1'b1);
	wr(TCR, 32'h0000012f);
	repeat (500) @(posedge core_clk_i);
	chk(de_seen > 0, 1'b1);
	// rejected timing write raises a masked status event
	wr(MKR, 32'h2);
	seed = xs(seed);
	wr(16'h8350, seed);
	rd(16'h8350, 32'hffffffff);
	rd(STR, 32'h2);
	chk(irq_o, 1'b1);
	wr(MKR, 32'h0);
	chk(irq_o, 1'b0);
	wr(MKR, 32'h2);
	wr(STR, 32'h2);
	rd(STR, 32'h2);
	chk(irq_o, 1'b0);
	// crt syncs off: panel syncs stay with the power sequencer
	wr(TCR, 32'h00000121);
	frame_hist(f0, f1, f2);
	chk(f0, 32'h3c);
	chk(f1, 32'h50);
	chk(f2, 32'h0);
	panel_power_on_i <= 1'b0;
	@(posedge core_clk_i);
	frame_hist(f0, f1, f2);
	chk(f0 + f1, 32'h0);
	panel_power_on_i <= 1'b1;
	// vertical interrupt holds until its enable is cleared
	wr(TCR, 32'h0000016f);
	for (i = 0; i < 1000 && vsync_irq_o !== 1'b1; i = i + 1)
		@(posedge core_clk_i);
	chk(vsync_irq_o, 1'b1);
	repeat (900) @(posedge core_clk_i);
	chk(vsync_irq_o, 1'b1);
	wr(TCR, 32'h0000012f);
	chk(vsync_irq_o, 1'b0);
	// blink half periods: cursor at both rates, text at rate 0
	chk(cursor_visible_o, 1'b1);
	chk(text_blink_visible_o, 1'b1);
	wr(TCR, 32'h000001af);
	tog(1'b0, f0);
	tog(1'b0, f0);
	tog(1'b0, f1);
	chk(f1 - f0, 32'h8);
	tog(1'b1, f0);
	tog(1'b1, f0);
	tog(1'b1, f1);
	chk(f1 - f0, 32'h10);
	wr(TCR, 32'h000101af);
	tog(1'b0, f0);
	tog(1'b0, f0);
	tog(1'b0, f1);
	chk(f1 - f0, 32'h10);
	// serial clock bit on the vsync pin, generator off
	for (i = 0; i < 4; i = i + 1) begin
		wr(TCR, {27'h0, i[0], 4'h0});
		chk(crt_vertical_sync_out_o, i[0]);
		chk(crt_horizontal_sync_out_o, 1'b0);
	end
	chk(pixel_port_enable_o, 1'b0);
	tally_and_finish;
end
endmodule // display_timing_output_control_bench
